// file: shared/bpcfg_defines.svh
// constants of the bus port configuration register block
// assumes inclusion by bare name from the package and the design files
`ifndef BPCFG_DEFINES_SVH
`define BPCFG_DEFINES_SVH

// access decode: alternate space and virtual address
`define BPCFG_ASI_CFG 8'h4a
`define BPCFG_VA_CFG 64'h0000_0000_0000_0000

// reset values of response data and configuration source
`define BPCFG_RST_DATA 64'h0000_0000_0000_0000
`define BPCFG_RST_CFG 27'h000_0000

// field positions of the 64-bit word
`define BPCFG_RSV_HI_MSB 63
`define BPCFG_RSV_HI_LSB 62
`define BPCFG_WB_MSB 61
`define BPCFG_WB_LSB 59
`define BPCFG_WRI_MSB 58
`define BPCFG_WRI_LSB 57
`define BPCFG_INT_MSB 56
`define BPCFG_INT_LSB 55
`define BPCFG_RSV_MID_MSB 54
`define BPCFG_RSV_MID_LSB 46
`define BPCFG_UC_MSB 45
`define BPCFG_UC_LSB 43
`define BPCFG_RSV_LO_MSB 42
`define BPCFG_RSV_LO_LSB 41
`define BPCFG_AM_MSB 40
`define BPCFG_AM_LSB 39
`define BPCFG_MODULE_CAPABILITY_VALUE_MSB 38
`define BPCFG_MODULE_CAPABILITY_VALUE_LSB 35
`define BPCFG_RSV_BIT 34
`define BPCFG_CLK_MSB 33
`define BPCFG_CLK_LSB 30
`define BPCFG_Q1_MSB 29
`define BPCFG_Q1_LSB 27
`define BPCFG_Q0_MSB 26
`define BPCFG_Q0_LSB 23
`define BPCFG_SREQ_BIT 22
`define BPCFG_MID_MSB 21
`define BPCFG_MID_LSB 17
`define BPCFG_CAP_MSB 16
`define BPCFG_CAP_LSB 0

// source bits inside the port identification register
`define BPCFG_PID_CAP_MSB 32
`define BPCFG_PID_CAP_LSB 16
`define BPCFG_PID_SREQ_BIT 35

// decode figures
`define BPCFG_PA_WIDTH_NARROW 6'h29
`define BPCFG_PA_WIDTH_WIDE 6'h2b
`define BPCFG_CLK_MIN_CODE 4'h4

`endif

// file: shared/bpcfg_pkg.sv
// types of the bus port configuration register block
// assumes bpcfg_defines.svh is on the include path
`include "bpcfg_defines.svh"

package bpcfg_pkg;

   // settings presented by the system configuration source
   typedef struct packed {
      logic [2:0] writeback_limit;
      logic [1:0] write_invalidate_limit;
      logic [1:0] interrupt_limit;
      logic [2:0] second_level_cache_size;
      logic [1:0] address_width_select;
      logic [3:0] module_capability_value;
      logic [3:0] clock_ratio;
      logic [2:0] class1_queue;
      logic [3:0] class0_queue;
   } bpcfg_cfg_s;

   // one access from the core on the alternate space path
   typedef struct packed {
      logic valid;
      logic write;
      logic supervisor;
      logic [7:0] asi;
      logic [63:0] va;
   } bpcfg_req_s;

   // answer to an access that decoded to this register
   typedef struct packed {
      logic valid;
      logic priv_fault;
      logic [63:0] data;
   } bpcfg_rsp_s;

   // decoded limits for neighbouring logic
   typedef struct packed {
      logic [3:0] writeback_max;
      logic [3:0] interrupt_max;
      logic [4:0] class1_depth;
      logic [4:0] class0_depth;
      logic [5:0] pa_width;
      logic [3:0] clock_ratio;
      logic reserved_code;
   } bpcfg_dec_s;

endpackage : bpcfg_pkg

// file: src/bpcfg_sync.sv
// two-flop level synchroniser for pins and straps
// assumes inputs are quasi-static levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module bpcfg_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // asynchronous level in, synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r; // first stage, read only by second stage
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // next values: plain shift through two stages
   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
      if (srst) begin
         meta_nxt = '0;
         q_nxt = '0;
      end
   end

   // registers only
   always_ff @(posedge clk) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
   end

   assign q = q_r;

endmodule : bpcfg_sync

`default_nettype wire

// file: src/bpcfg_reg.sv
// bus port configuration register, read over the alternate space path
// assumes one core access port on clk, pins and straps from outside,
// and the port identification register as logic on the same clock
//
// Summary of operation
// - only alternate space 4a, address 0, core path
// - supervisor reads only; writes change nothing
// - bits 16:0 and 22 mirror port id
// - bits 21:17 from module identifier pins
// - reserved ranges read as zero
// - writeback limit code 61:59, 1/2/4/8
// - write-invalidate limit code in 58:57
// - interrupt limit code 56:55, 1 or 8
// - address width 40:39, 41 or 43 bits
// - capability value 38:35 from system source
// - clock ratio 33:30, codes 4..15
// - class 1 queue depth in 29:27
// - class 0 queue depth in 26:23
// - bits 16:0 composite of four copied fields
`timescale 1ns/1ps
`default_nettype none
`include "bpcfg_defines.svh"

module bpcfg_reg (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // core access path
   input wire bpcfg_pkg::bpcfg_req_s req,
   output bpcfg_pkg::bpcfg_rsp_s rsp,
   // external pins and straps, asynchronous
   input wire logic [4:0] master_identifier_pins,
   input wire bpcfg_pkg::bpcfg_cfg_s system_config_source,
   // port identification register, same clock
   input wire logic [63:0] port_identification_register,
   // decoded limits for neighbouring logic
   output bpcfg_pkg::bpcfg_dec_s dec
);

   // ------------------------------------------------------------
   // decode functions
   // ------------------------------------------------------------

   // writeback limit: codes above 3 saturate at 8
   function automatic logic [3:0] wb_count(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h8;
      case (code)
         3'h0: n = 4'h1;
         3'h1: n = 4'h2;
         3'h2: n = 4'h4;
         default: n = 4'h8; // 3 and the discouraged codes
      endcase
      return n;
   endfunction : wb_count

   // interrupt packet limit: anything but zero means 8
   function automatic logic [3:0] int_count(input logic [1:0] code);
      logic [3:0] n;
      n = (code == 2'h0) ? 4'h1 : 4'h8;
      return n;
   endfunction : int_count

   // class 1 queue: 0..2 give 1, 3..6 give 4, 7 gives 8
   function automatic logic [4:0] q1_depth(input logic [2:0] code);
      logic [4:0] n;
      n = 5'h01;
      if (code == 3'h7) begin
         n = 5'h08;
      end else if (code >= 3'h3) begin
         n = 5'h04;
      end
      return n;
   endfunction : q1_depth

   // class 0 queue: 0..2 give 1, 3..14 give 4, 15 gives 16
   function automatic logic [4:0] q0_depth(input logic [3:0] code);
      logic [4:0] n;
      n = 5'h01;
      if (code == 4'hf) begin
         n = 5'h10;
      end else if (code >= 4'h3) begin
         n = 5'h04;
      end
      return n;
   endfunction : q0_depth

   // physical address width; reserved codes give zero
   function automatic logic [5:0] pa_bits(input logic [1:0] code);
      logic [5:0] n;
      n = 6'h00;
      case (code)
         2'h0: n = `BPCFG_PA_WIDTH_NARROW;
         2'h1: n = `BPCFG_PA_WIDTH_WIDE;
         default: n = 6'h00; // reserved
      endcase
      return n;
   endfunction : pa_bits

   // ------------------------------------------------------------
   // pin and strap synchronisers
   // ------------------------------------------------------------

   logic [4:0] mid_s; // module identifier, synchronised
   logic [26:0] cfg_raw_s; // config source, synchronised
   bpcfg_pkg::bpcfg_cfg_s cfg_s; // same, typed view

   // identifier pins come from the board, two flops first
   bpcfg_sync #(.W(5)) u_mid_sync (
      .clk(clk),
      .srst(srst),
      .d(master_identifier_pins),
      .q(mid_s)
   );

   // straps are static in practice but still cross a domain
   bpcfg_sync #(.W(27)) u_cfg_sync (
      .clk(clk),
      .srst(srst),
      .d(system_config_source),
      .q(cfg_raw_s)
   );

   assign cfg_s = bpcfg_pkg::bpcfg_cfg_s'(cfg_raw_s);

   // ------------------------------------------------------------
   // word assembly
   // ------------------------------------------------------------

   logic [63:0] word; // live register image

   // port id bits from this cycle's input; pin and strap fields two cycles late through the synchronisers
   always_comb begin
      word = `BPCFG_RST_DATA; // reserved bits stay zero
      word[`BPCFG_WB_MSB:`BPCFG_WB_LSB] = cfg_s.writeback_limit;
      word[`BPCFG_WRI_MSB:`BPCFG_WRI_LSB] =
         cfg_s.write_invalidate_limit;
      word[`BPCFG_INT_MSB:`BPCFG_INT_LSB] = cfg_s.interrupt_limit;
      word[`BPCFG_UC_MSB:`BPCFG_UC_LSB] = cfg_s.second_level_cache_size;
      word[`BPCFG_AM_MSB:`BPCFG_AM_LSB] = cfg_s.address_width_select;
      word[`BPCFG_MODULE_CAPABILITY_VALUE_MSB:`BPCFG_MODULE_CAPABILITY_VALUE_LSB] =
         cfg_s.module_capability_value;
      word[`BPCFG_CLK_MSB:`BPCFG_CLK_LSB] = cfg_s.clock_ratio;
      word[`BPCFG_Q1_MSB:`BPCFG_Q1_LSB] = cfg_s.class1_queue;
      word[`BPCFG_Q0_MSB:`BPCFG_Q0_LSB] = cfg_s.class0_queue;
      // slave request size copy
      word[`BPCFG_SREQ_BIT] =
         port_identification_register[`BPCFG_PID_SREQ_BIT];
      word[`BPCFG_MID_MSB:`BPCFG_MID_LSB] = mid_s;
      // interrupt, write data and request queue sizes plus
      // capability flags, copied as one 17-bit slice
      word[`BPCFG_CAP_MSB:`BPCFG_CAP_LSB] =
         port_identification_register[`BPCFG_PID_CAP_MSB:
                                      `BPCFG_PID_CAP_LSB];
      // explicit zeroing keeps the reserved holes obvious
      word[`BPCFG_RSV_HI_MSB:`BPCFG_RSV_HI_LSB] = 2'h0;
      word[`BPCFG_RSV_MID_MSB:`BPCFG_RSV_MID_LSB] = 9'h000;
      word[`BPCFG_RSV_LO_MSB:`BPCFG_RSV_LO_LSB] = 2'h0;
      word[`BPCFG_RSV_BIT] = 1'b0;
   end

   // ------------------------------------------------------------
   // access decode and response
   // ------------------------------------------------------------

   logic hit; // access addresses this register
   bpcfg_pkg::bpcfg_rsp_s rsp_r;
   bpcfg_pkg::bpcfg_rsp_s rsp_nxt;

   // only the core's alternate space path reaches us; there is
   // no slave-bus port, so a system bus read can never see it
   assign hit = req.valid && (req.asi == `BPCFG_ASI_CFG) &&
                (req.va == `BPCFG_VA_CFG);

   // next response: one cycle after the access
   always_comb begin
      rsp_nxt.valid = 1'b0;
      rsp_nxt.priv_fault = 1'b0;
      rsp_nxt.data = `BPCFG_RST_DATA;
      if (srst) begin
         // response held quiet through reset
         rsp_nxt.valid = 1'b0;
      end else if (hit) begin
         rsp_nxt.valid = 1'b1;
         if (req.write) begin
            // write acknowledged, nothing stored
            rsp_nxt.data = `BPCFG_RST_DATA;
         end else if (!req.supervisor) begin
            // user-mode read is refused, data withheld
            rsp_nxt.priv_fault = 1'b1;
         end else begin
            // whole word from one sample, never torn
            rsp_nxt.data = word;
         end
      end
   end

   // response registers
   always_ff @(posedge clk) begin
      rsp_r <= rsp_nxt;
   end

   assign rsp = rsp_r;

   // ------------------------------------------------------------
   // decoded limits
   // ------------------------------------------------------------

   bpcfg_pkg::bpcfg_dec_s dec_r;
   bpcfg_pkg::bpcfg_dec_s dec_nxt;

   // decoded every cycle so neighbours never wait on a read;
   // costs a few flops, saves a decode in every consumer
   always_comb begin
      dec_nxt.writeback_max = wb_count(cfg_s.writeback_limit);
      dec_nxt.interrupt_max = int_count(cfg_s.interrupt_limit);
      dec_nxt.class1_depth = q1_depth(cfg_s.class1_queue);
      dec_nxt.class0_depth = q0_depth(cfg_s.class0_queue);
      dec_nxt.pa_width = pa_bits(cfg_s.address_width_select);
      dec_nxt.clock_ratio = cfg_s.clock_ratio;
      // reserved address mode or ratio below 4:1 is flagged
      dec_nxt.reserved_code =
         (cfg_s.address_width_select[1] == 1'b1) ||
         (cfg_s.clock_ratio < `BPCFG_CLK_MIN_CODE);
      if (srst) begin
         dec_nxt = bpcfg_pkg::bpcfg_dec_s'('0);
      end
   end

   // decoded registers
   always_ff @(posedge clk) begin
      dec_r <= dec_nxt;
   end

   assign dec = dec_r;

endmodule : bpcfg_reg

`default_nettype wire

// file: dv/bpcfg_reg_sva.sv
// checker of the configuration register answers and word layout
// assumes binding to bpcfg_reg, seeing only its ports
`timescale 1ns/1ps
`default_nettype none

module bpcfg_reg_sva (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // core access path
   input wire bpcfg_pkg::bpcfg_req_s req,
   input wire bpcfg_pkg::bpcfg_rsp_s rsp,
   // pins, straps, port id, decoded limits
   input wire logic [4:0] master_identifier_pins,
   input wire bpcfg_pkg::bpcfg_cfg_s system_config_source,
   input wire logic [63:0] port_identification_register,
   input wire bpcfg_pkg::bpcfg_dec_s dec
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // access aimed at this register
   wire logic hit = req.valid && req.asi == 8'h4a && req.va == 64'h0;
   // supervisor read of it
   wire logic rd_ok = hit && !req.write && req.supervisor;

   a_hit_answer: assert property (hit |=> rsp.valid)
      else $error("hit without answer");
   a_miss_silent: assert property (!hit |=> !rsp.valid && rsp.data == 64'h0)
      else $error("answer without hit");
   a_user_fault: assert property (hit && !req.write && !req.supervisor |=>
      rsp.priv_fault && rsp.data == 64'h0) else $error("user read not refused");
   a_write_ignored: assert property (hit && req.write |=>
      !rsp.priv_fault && rsp.data == 64'h0) else $error("write answer wrong");
   a_reserved_zero: assert property (rsp.valid |-> rsp.data[63:62] == 2'h0 &&
      rsp.data[54:46] == 9'h000 && rsp.data[42:41] == 2'h0 && !rsp.data[34])
      else $error("reserved bits set");
   a_port_mirror: assert property (rd_ok |=> !rsp.priv_fault &&
      rsp.data[16:0] == $past(port_identification_register[32:16]) &&
      rsp.data[22] == $past(port_identification_register[35])) else $error("mirror wrong");
   // synchronisers lag two edges, so pins are compared three samples back
   a_pin_ident: assert property (rd_ok && !$past(srst) && !$past(srst, 2) |=>
      rsp.data[21:17] == $past(master_identifier_pins, 3)) else $error("module id wrong");
   a_strap_fields: assert property (rd_ok && !$past(srst) && !$past(srst, 2) |=>
      {rsp.data[61:55], rsp.data[45:43], rsp.data[40:35], rsp.data[33:23]} ==
      $past(system_config_source, 3)) else $error("strap fields wrong");

   // main scenarios reached
   c_good_read: cover property (rd_ok ##1 rsp.valid);
   c_user_read: cover property (hit && !req.write && !req.supervisor);
   c_write: cover property (hit && req.write);
   c_back_to_back: cover property (hit ##1 hit);
endmodule : bpcfg_reg_sva

bind bpcfg_reg bpcfg_reg_sva u_sva (.clk(clk), .srst(srst), .req(req), .rsp(rsp),
   .master_identifier_pins(master_identifier_pins),
   .system_config_source(system_config_source),
   .port_identification_register(port_identification_register), .dec(dec));

`default_nettype wire

// file: dv/bpcfg_reg_tb.sv
// self-checking bench of the configuration register
// assumes bpcfg_reg, its package and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none

module bpcfg_reg_tb;
   logic clk = 1'b0; // 20 MHz
   logic srst = 1'b1; // held at start
   bpcfg_pkg::bpcfg_req_s req = '0; // core access
   bpcfg_pkg::bpcfg_rsp_s rsp;
   logic [4:0] pins = 5'h00; // module id pins
   bpcfg_pkg::bpcfg_cfg_s cfg = '0; // straps
   logic [63:0] pid = 64'h0; // port id register
   bpcfg_pkg::bpcfg_dec_s dec;
   bpcfg_pkg::bpcfg_rsp_s exp_r; // expected answer
   logic [31:0] seed = 32'h0000_002a; // fixed seed
   int miscompares = 0;
   int check_count = 0;

   // free-running clock
   always #25 clk = ~clk;

   bpcfg_reg dut (.clk(clk), .srst(srst), .req(req), .rsp(rsp),
      .master_identifier_pins(pins), .system_config_source(cfg),
      .port_identification_register(pid), .dec(dec));

   // next state of the linear feedback shift register
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // next random word, advancing the fixed-seed sequence
   task automatic draw(output logic [31:0] v);
      seed = lfsr(seed);
      v = seed;
   endtask : draw

   // decoded limits worked out from the code tables
   function automatic bpcfg_pkg::bpcfg_dec_s dec_of();
      bpcfg_pkg::bpcfg_dec_s d;
      d = '0;
      d.writeback_max = (cfg.writeback_limit >= 3'h3) ? 4'h8 :
         (cfg.writeback_limit == 3'h2) ? 4'h4 : (cfg.writeback_limit == 3'h1) ? 4'h2 : 4'h1;
      d.interrupt_max = (cfg.interrupt_limit == 2'h0) ? 4'h1 : 4'h8;
      d.class1_depth = (cfg.class1_queue == 3'h7) ? 5'h08 :
         (cfg.class1_queue >= 3'h3) ? 5'h04 : 5'h01;
      d.class0_depth = (cfg.class0_queue == 4'hf) ? 5'h10 :
         (cfg.class0_queue >= 4'h3) ? 5'h04 : 5'h01;
      d.pa_width = (cfg.address_width_select == 2'h0) ? 6'h29 :
         (cfg.address_width_select == 2'h1) ? 6'h2b : 6'h00;
      d.clock_ratio = cfg.clock_ratio;
      // reserved address mode or a ratio code below four
      d.reserved_code = cfg.address_width_select[1] || (cfg.clock_ratio < 4'h4);
      return d;
   endfunction : dec_of

   // register word built from the field layout
   function automatic logic [63:0] word_of();
      return {2'h0, cfg.writeback_limit, cfg.write_invalidate_limit, cfg.interrupt_limit,
         9'h000, cfg.second_level_cache_size, 2'h0, cfg.address_width_select,
         cfg.module_capability_value, 1'b0, cfg.clock_ratio, cfg.class1_queue,
         cfg.class0_queue, pid[35], pins, pid[32:16]};
   endfunction : word_of

   // answer due one edge after an access
   function automatic bpcfg_pkg::bpcfg_rsp_s answer_of(input bpcfg_pkg::bpcfg_req_s q);
      bpcfg_pkg::bpcfg_rsp_s a;
      a = '0;
      if (q.valid && q.asi == 8'h4a && q.va == 64'h0) begin
         a.valid = 1'b1;
         a.priv_fault = !q.write && !q.supervisor;
         // only supervisor reads carry the word
         if (!q.write && q.supervisor) begin
            a.data = word_of();
         end
      end
      return a;
   endfunction : answer_of

   // one comparison
   task automatic check(input logic [65:0] seen, input logic [65:0] want);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   // verdict and end of run
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // main sequence: strap sets, each followed by back-to-back accesses
   initial begin
      logic [31:0] r;
      logic [31:0] k;
      repeat (20) @(negedge clk);
      check(rsp, 66'h0);
      srst = 1'b0;
      for (int s = 0; s < 24; s++) begin
         draw(r);
         draw(k);
         // first set all ones, so reserved bits are tested hardest
         pins = (s == 0) ? 5'h1f : k[4:0];
         cfg = (s == 0) ? '1 : r[26:0];
         // idle while straps settle
         repeat (4) begin
            @(negedge clk);
            check(rsp, 66'h0);
         end
         for (int i = 0; i < 12; i++) begin
            draw(r);
            draw(k);
            pid = (s == 0) ? '1 : {k, r};
            req.valid = r[31:29] != 3'h0;
            req.write = r[28] & r[27];
            req.supervisor = r[26] | r[25];
            // sometimes a foreign space or address
            req.asi = (r[24:22] == 3'h0) ? r[7:0] : 8'h4a;
            req.va = (r[21:19] == 3'h0) ? {56'h0, r[15:8]} : 64'h0;
            exp_r = answer_of(req);
            @(negedge clk);
            check(rsp, exp_r);
            check(dec, dec_of());
         end
         req = '0;
      end
      // reset in mid-run swallows a pending read
      srst = 1'b1;
      req = '{valid: 1'b1, write: 1'b0, supervisor: 1'b1, asi: 8'h4a, va: 64'h0};
      repeat (2) @(negedge clk);
      check(rsp, 66'h0);
      close_out();
   end

   // hang guard
   initial begin
      #(50 * 2000);
      miscompares++;
      close_out();
   end
endmodule : bpcfg_reg_tb

`default_nettype wire
